// File: src/csam_core_state.sv
`timescale 1ns/1ps
module csam_core_state
	import csam_pkg::*;
(
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	input  wire logic                  low_voltage_reset,
	// register loads from the sequencer
	input  wire logic                  acc_load,
	input  wire logic                  x_load,
	input  wire logic                  y_load,
	input  wire logic [7:0]            load_data,
	input  wire logic                  psr_load,
	input  wire logic                  flag_write,
	input  wire logic [2:0]            flag_index,
	input  wire logic                  flag_value,
	input  wire logic                  int_entry,
	input  wire logic                  int_is_break,
	input  wire logic                  pc_load,
	input  wire logic [15:0]           pc_in,
	input  wire logic                  sp_load,
	// alu request
	input  wire logic                  alu_go,
	input  wire csam_pkg::csam_alu_op_t alu_op,
	input  wire logic [7:0]            alu_operand,
	// memory access requests
	input  wire logic                  fetch_req,
	input  wire logic                  push_req,
	input  wire logic                  pull_req,
	input  wire logic                  data_req,
	input  wire logic                  data_we,
	input  wire logic [15:0]           base_addr,
	input  wire csam_pkg::csam_index_t index_sel,
	input  wire logic [7:0]            wdata,
	// peripheral side inputs
	input  wire logic                  hardware_interrupt_request,
	input  wire logic [7:0]            irq_event,
	input  wire logic                  vdd1_level,
	// programmer-visible state
	output logic [7:0]                 acc_r,
	output logic [7:0]                 x_r,
	output logic [7:0]                 y_r,
	output logic [7:0]                 psr_r,
	output logic [15:0]                program_counter_r,
	output logic [7:0]                 sp_r,
	// memory side
	output logic [15:0]                addr_bus_r,
	output logic                       ram_sel_r,
	output logic [RAM_ADDR_W-1:0]      ram_addr_r,
	output logic                       sfr_sel_r,
	output logic                       rom_sel_r,
	output logic                       mem_we_r,
	output logic [7:0]                 mem_wdata_r,
	output logic [7:0]                 sfr_rdata_r,
	// interrupt and protection state
	output logic                       irq_take_r,
	output logic                       unlocked_r
);
	import csam_pkg::*;

	logic                rst;
	logic [15:0]         eff_addr;
	logic [15:0]         acc_addr;
	logic                acc_go;
	logic                acc_wr;
	logic [7:0]          acc_wd;
	logic                push_go;
	logic                pull_go;
	csam_region_t        acc_rgn;
	logic [5:0]          sfr_idx;
	logic                sfr_wr;
	logic [7:0]          sfr_r [0:SFR_COUNT-1];
	logic [7:0]          alu_res;
	logic                alu_c;
	logic                alu_v;
	logic                alu_wr_acc;
	logic                alu_carry_upd;
	logic                alu_v_upd;
	logic [8:0]          bin_sum;
	logic [8:0]          bin_dif;
	logic [4:0]          nib_lo;
	logic [4:0]          nib_hi;
	logic [7:0]          status_clr;

	// address decode, shared by access path and register writes
	function automatic csam_region_t region_of(input logic [15:0] a);
		// ram and its mirror
		if (a <= RAM_LOW_END || (a >= RAM_MIRROR_BASE && a <= RAM_MIRROR_END))
			region_of = CSAM_RGN_RAM;
		// zero-page register window
		else if (a >= SFR_BASE && a <= SFR_END)
			region_of = CSAM_RGN_SFR;
		// program and constant rom
		else if (a >= ROM_BASE)
			region_of = CSAM_RGN_ROM;
		else
			region_of = CSAM_RGN_NONE;
	endfunction

	// implemented-bit mask or reset value of one register
	function automatic logic [7:0] sfr_field(input logic [7:0] ofs, input logic want_mask);
		logic [15:0] spec;
		case (ofs)
			OFS_MAIN_CLOCK_MANAGER: spec = {MASK_CLOCK_MGR, RST_ZERO};
			OFS_SYSTEM_STATUS: spec = {MASK_BIT7, RST_ZERO};
			OFS_INTERRUPT_ENABLE, OFS_HALT_RELEASE_ENABLE: spec = {MASK_LOW7, RST_ZERO};
			OFS_INTERRUPT_STATUS: spec = {MASK_ALL, RST_ZERO};
			OFS_TIMER0_COUNT, OFS_TIMER1_COUNT, OFS_TIMER2_COUNT_LOW,
			OFS_TIMER2_COUNT_HIGH: spec = {MASK_ALL, RST_COUNT};
			OFS_TIMER0_CONTROL, OFS_TIMER1_CONTROL: spec = {MASK_LOW5, RST_ZERO};
			OFS_TIMER2_CONTROL: spec = {MASK_LOW6, RST_ZERO};
			OFS_DIVIDER_SELECT, OFS_CALENDAR_COUNT_0,
			OFS_AUDIO_CH1_ENVELOPE, OFS_AUDIO_CH2_ENVELOPE: spec = {MASK_ALL, RST_ZERO};
			OFS_PORT0_DATA, OFS_PORT0_DIRECTION, OFS_PORT0_PULL_HIGH, OFS_PORT0_OPEN_DRAIN,
			OFS_PORT1_DATA, OFS_PORT1_DIRECTION, OFS_PORT1_PULL_HIGH, OFS_PORT1_OPEN_DRAIN,
			OFS_PORT2_DATA, OFS_PORT2_DIRECTION, OFS_PORT2_PULL_HIGH, OFS_PORT2_OPEN_DRAIN,
			OFS_PORT3_DATA, OFS_PORT3_DIRECTION, OFS_PORT3_PULL_HIGH,
			OFS_PORT3_OPEN_DRAIN: spec = {MASK_ALL, RST_ZERO};
			OFS_PORT4_DATA, OFS_PORT4_OPEN_DRAIN: spec = {MASK_LOW6, RST_ZERO};
			OFS_MEMORY_BANK_SELECT: spec = {MASK_BIT0, RST_ZERO};
			OFS_AUDIO_OUTPUT_CTRL: spec = {MASK_AUDIO, RST_ZERO};
			// key is write-only and holes are empty: both read zero
			default: spec = {RST_ZERO, RST_ZERO};
		endcase
		sfr_field = want_mask ? spec[15:8] : spec[7:0];
	endfunction

	// low-voltage trip
	// detector joins reset
	assign rst = !reset_n || low_voltage_reset;

	always_comb begin
		case (index_sel)
			CSAM_IDX_X: eff_addr = base_addr + {8'h00, x_r};
			CSAM_IDX_Y: eff_addr = base_addr + {8'h00, y_r};
			default: eff_addr = base_addr;
		endcase
	end

	// one access per cycle: fetch, then push, then pull, then data
	always_comb begin
		acc_go = 1'b1;
		acc_wr = 1'b0;
		acc_wd = wdata;
		push_go = 1'b0;
		pull_go = 1'b0;
		if (fetch_req) begin
			acc_addr = program_counter_r;
		end else if (push_req) begin
			acc_addr = {STACK_PAGE, sp_r};
			acc_wr = 1'b1;
			acc_wd = wdata;
			push_go = 1'b1;
		end else if (pull_req) begin
			acc_addr = {STACK_PAGE, 8'(sp_r + 8'h01)};
			pull_go = 1'b1;
		end else begin
			acc_addr = eff_addr;
			acc_wr = data_we;
			acc_go = data_req;
		end
	end

	assign acc_rgn = region_of(acc_addr);
	assign sfr_idx = acc_addr[5:0];
	assign sfr_wr = acc_go && acc_wr && acc_rgn == CSAM_RGN_SFR;

	// memory-side strobes, registered
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_bus_r <= 16'h0000;
			ram_sel_r <= 1'b0;
			ram_addr_r <= '0;
			sfr_sel_r <= 1'b0;
			rom_sel_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_wdata_r <= 8'h00;
		end else begin
			addr_bus_r <= acc_addr;
			ram_sel_r <= acc_go && acc_rgn == CSAM_RGN_RAM;
			ram_addr_r <= acc_addr[RAM_ADDR_W-1:0];
			sfr_sel_r <= acc_go && acc_rgn == CSAM_RGN_SFR;
			rom_sel_r <= acc_go && !acc_wr && acc_rgn == CSAM_RGN_ROM;
			// write strobe only for ram; sfr writes stay inside, rom and holes drop them
			mem_we_r <= acc_go && acc_wr && acc_rgn == CSAM_RGN_RAM;
			mem_wdata_r <= acc_wd;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			program_counter_r <= PC_RESET;
		else if (pc_load)
			program_counter_r <= pc_in;
		else if (fetch_req)
			program_counter_r <= program_counter_r + 16'h0001;
	end

	// reset value only keeps simulation clean; software still sets it up
	// push down, pull up
	always_ff @(posedge ref_clk) begin
		if (rst)
			sp_r <= SP_RESET;
		else if (sp_load)
			sp_r <= load_data;
		else if (push_go)
			sp_r <= sp_r - 8'h01;
		else if (pull_go)
			sp_r <= sp_r + 8'h01;
	end

	// alu; decimal add adjusts per nibble, decimal subtract adjusts the binary difference; overflow from binary form
	always_comb begin
		bin_sum = {1'b0, acc_r} + {1'b0, alu_operand} + {8'h00, psr_r[PSR_C]};
		bin_dif = {1'b0, acc_r} - {1'b0, alu_operand} - {8'h00, !psr_r[PSR_C]};
		nib_lo = 5'h00;
		nib_hi = 5'h00;
		alu_res = alu_operand;
		alu_c = psr_r[PSR_C];
		alu_v = psr_r[PSR_V];
		alu_wr_acc = 1'b1;
		alu_carry_upd = 1'b0;
		alu_v_upd = 1'b0;
		case (alu_op)
			CSAM_ALU_ADC: begin
				alu_carry_upd = 1'b1;
				alu_v_upd = 1'b1;
				alu_v = (acc_r[7] == alu_operand[7]) && (bin_sum[7] != acc_r[7]);
				if (psr_r[PSR_D]) begin
					nib_lo = {1'b0, acc_r[3:0]} + {1'b0, alu_operand[3:0]}
						+ {4'h0, psr_r[PSR_C]};
					if (nib_lo > 5'd9)
						nib_lo = nib_lo + 5'd6;
					nib_hi = {1'b0, acc_r[7:4]} + {1'b0, alu_operand[7:4]}
						+ {4'h0, nib_lo[4]};
					if (nib_hi > 5'd9)
						nib_hi = nib_hi + 5'd6;
					alu_res = {nib_hi[3:0], nib_lo[3:0]};
					alu_c = nib_hi[4];
				end else begin
					alu_res = bin_sum[7:0];
					alu_c = bin_sum[8];
				end
			end
			CSAM_ALU_SBC: begin
				alu_carry_upd = 1'b1;
				alu_v_upd = 1'b1;
				alu_v = (acc_r[7] != alu_operand[7]) && (bin_dif[7] != acc_r[7]);
				alu_c = !bin_dif[8];
				alu_res = bin_dif[7:0];
				if (psr_r[PSR_D]) begin
					nib_lo = {1'b0, acc_r[3:0]} - {1'b0, alu_operand[3:0]}
						- {4'h0, !psr_r[PSR_C]};
					if (nib_lo[4])
						alu_res = alu_res - 8'h06;
					if (bin_dif[8])
						alu_res = alu_res - 8'h60;
				end
			end
			CSAM_ALU_CMP: begin
				alu_wr_acc = 1'b0;
				alu_carry_upd = 1'b1;
				alu_res = acc_r - alu_operand;
				alu_c = acc_r >= alu_operand;
			end
			CSAM_ALU_AND: alu_res = acc_r & alu_operand;
			CSAM_ALU_ORA: alu_res = acc_r | alu_operand;
			CSAM_ALU_EOR: alu_res = acc_r ^ alu_operand;
			CSAM_ALU_ASL: begin
				alu_carry_upd = 1'b1;
				alu_res = {acc_r[6:0], 1'b0};
				alu_c = acc_r[7];
			end
			CSAM_ALU_LSR: begin
				alu_carry_upd = 1'b1;
				alu_res = {1'b0, acc_r[7:1]};
				alu_c = acc_r[0];
			end
			CSAM_ALU_ROL: begin
				alu_carry_upd = 1'b1;
				alu_res = {acc_r[6:0], psr_r[PSR_C]};
				alu_c = acc_r[7];
			end
			CSAM_ALU_ROR: begin
				alu_carry_upd = 1'b1;
				alu_res = {psr_r[PSR_C], acc_r[7:1]};
				alu_c = acc_r[0];
			end
			default: alu_res = alu_operand;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			acc_r <= 8'h00;
		else if (acc_load)
			acc_r <= load_data;
		else if (alu_go && alu_wr_acc)
			acc_r <= alu_res;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			x_r <= 8'h00;
			y_r <= 8'h00;
		end else begin
			if (x_load)
				x_r <= load_data;
			if (y_load)
				y_r <= load_data;
		end
	end

	// psr_load wins outright; otherwise later updates in this block win over earlier ones
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			psr_r <= PSR_RESET;
		end else if (psr_load) begin
			psr_r <= load_data | (8'h01 << PSR_ONE);
		end else begin
			if (alu_go) begin
				psr_r[PSR_N] <= alu_res[7];
				psr_r[PSR_Z] <= alu_res == 8'h00;
				if (alu_carry_upd)
					psr_r[PSR_C] <= alu_c;
				if (alu_v_upd)
					psr_r[PSR_V] <= alu_v;
			end else if (acc_load || x_load || y_load) begin
				psr_r[PSR_N] <= load_data[7];
				psr_r[PSR_Z] <= load_data == 8'h00;
			end
			if (flag_write && flag_index != 3'(PSR_ONE))
				psr_r[flag_index] <= flag_value;
			if (int_entry) begin
				psr_r[PSR_B] <= int_is_break;
				psr_r[PSR_I] <= 1'b1;
			end
			psr_r[PSR_ONE] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			irq_take_r <= 1'b0;
		else
			irq_take_r <= !psr_r[PSR_I] && (hardware_interrupt_request
				|| (sfr_r[OFS_INTERRUPT_STATUS[5:0]] & sfr_r[OFS_INTERRUPT_ENABLE[5:0]])
				!= 8'h00);
	end

	// key arms one following write, any write disarms it
	always_ff @(posedge ref_clk) begin
		if (rst)
			unlocked_r <= 1'b0;
		else if (sfr_wr && {2'b11, sfr_idx} == OFS_WRITE_UNLOCK_KEY)
			unlocked_r <= acc_wd == UNLOCK_PATTERN;
		else if (acc_go && acc_wr)
			unlocked_r <= 1'b0;
	end

	// write-one clear; watchdog bit only while unlocked
	always_comb begin
		status_clr = 8'h00;
		if (sfr_wr && {2'b11, sfr_idx} == OFS_INTERRUPT_STATUS) begin
			status_clr = acc_wd;
			status_clr[STATUS_WDT_BIT] = acc_wd[STATUS_WDT_BIT] && unlocked_r;
		end
	end

	// register window storage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < SFR_COUNT; i++)
				sfr_r[i] <= sfr_field(SFR_BASE[7:0] + 8'(i), 1'b0);
		end else begin
			if (sfr_wr && {2'b11, sfr_idx} != OFS_INTERRUPT_STATUS
				&& {2'b11, sfr_idx} != OFS_SYSTEM_STATUS
				&& ({2'b11, sfr_idx} != OFS_MAIN_CLOCK_MANAGER || unlocked_r))
				sfr_r[sfr_idx] <= acc_wd & sfr_field({2'b11, sfr_idx}, 1'b1);
			// new events win over a same-cycle clear
			sfr_r[OFS_INTERRUPT_STATUS[5:0]] <=
				(sfr_r[OFS_INTERRUPT_STATUS[5:0]] & ~status_clr) | irq_event;
			sfr_r[OFS_SYSTEM_STATUS[5:0]] <= {vdd1_level, 7'h00};
		end
	end

	// register read port, valid the cycle after the access
	always_ff @(posedge ref_clk) begin
		if (rst)
			sfr_rdata_r <= 8'h00;
		else if (acc_go && !acc_wr && acc_rgn == CSAM_RGN_SFR)
			sfr_rdata_r <= sfr_r[sfr_idx] & sfr_field({2'b11, sfr_idx}, 1'b1);
	end
endmodule

// File: src/csam_pkg.sv
package csam_pkg;
	// address map
	localparam logic [15:0] RAM_LOW_END     = 16'h007f;
	localparam logic [15:0] RAM_MIRROR_BASE = 16'h0100;
	localparam logic [15:0] RAM_MIRROR_END  = 16'h017f;
	localparam logic [15:0] SFR_BASE        = 16'h00c0;
	localparam logic [15:0] SFR_END         = 16'h00ff;
	localparam logic [15:0] ROM_BASE        = 16'h8000;
	localparam logic [7:0]  STACK_PAGE      = 8'h01;
	localparam int          RAM_ADDR_W      = 7;
	localparam int          SFR_COUNT       = 64;
	// special-function register offsets
	localparam logic [7:0] OFS_MAIN_CLOCK_MANAGER  = 8'hc0;
	localparam logic [7:0] OFS_SYSTEM_STATUS       = 8'hc1;
	localparam logic [7:0] OFS_INTERRUPT_ENABLE    = 8'hc2;
	localparam logic [7:0] OFS_INTERRUPT_STATUS    = 8'hc3;
	localparam logic [7:0] OFS_HALT_RELEASE_ENABLE = 8'hc4;
	localparam logic [7:0] OFS_TIMER0_COUNT        = 8'hc8;
	localparam logic [7:0] OFS_TIMER0_CONTROL      = 8'hc9;
	localparam logic [7:0] OFS_TIMER1_COUNT        = 8'hca;
	localparam logic [7:0] OFS_TIMER1_CONTROL      = 8'hcb;
	localparam logic [7:0] OFS_TIMER2_COUNT_LOW    = 8'hcc;
	localparam logic [7:0] OFS_TIMER2_COUNT_HIGH   = 8'hcd;
	localparam logic [7:0] OFS_TIMER2_CONTROL      = 8'hce;
	localparam logic [7:0] OFS_DIVIDER_SELECT      = 8'hcf;
	localparam logic [7:0] OFS_PORT0_DATA          = 8'hd2;
	localparam logic [7:0] OFS_PORT0_DIRECTION     = 8'hd3;
	localparam logic [7:0] OFS_PORT0_PULL_HIGH     = 8'hd4;
	localparam logic [7:0] OFS_PORT0_OPEN_DRAIN    = 8'hd5;
	localparam logic [7:0] OFS_PORT1_DATA          = 8'hd7;
	localparam logic [7:0] OFS_PORT1_DIRECTION     = 8'hd8;
	localparam logic [7:0] OFS_PORT1_PULL_HIGH     = 8'hd9;
	localparam logic [7:0] OFS_PORT1_OPEN_DRAIN    = 8'hda;
	localparam logic [7:0] OFS_PORT2_DATA          = 8'hdc;
	localparam logic [7:0] OFS_PORT2_DIRECTION     = 8'hdd;
	localparam logic [7:0] OFS_PORT2_PULL_HIGH     = 8'hde;
	localparam logic [7:0] OFS_PORT2_OPEN_DRAIN    = 8'hdf;
	localparam logic [7:0] OFS_CALENDAR_COUNT_0    = 8'he0;
	localparam logic [7:0] OFS_PORT3_DATA          = 8'he8;
	localparam logic [7:0] OFS_PORT3_DIRECTION     = 8'he9;
	localparam logic [7:0] OFS_PORT3_PULL_HIGH     = 8'hea;
	localparam logic [7:0] OFS_PORT3_OPEN_DRAIN    = 8'heb;
	localparam logic [7:0] OFS_PORT4_DATA          = 8'hec;
	localparam logic [7:0] OFS_PORT4_OPEN_DRAIN    = 8'hed;
	localparam logic [7:0] OFS_MEMORY_BANK_SELECT  = 8'hf2;
	localparam logic [7:0] OFS_WRITE_UNLOCK_KEY    = 8'hf3;
	localparam logic [7:0] OFS_AUDIO_CH1_ENVELOPE  = 8'hf7;
	localparam logic [7:0] OFS_AUDIO_CH2_ENVELOPE  = 8'hf8;
	localparam logic [7:0] OFS_AUDIO_OUTPUT_CTRL   = 8'hf9;
	// implemented-bit masks and reset values
	localparam logic [7:0] MASK_ALL       = 8'hff;
	localparam logic [7:0] MASK_LOW7      = 8'h7f;
	localparam logic [7:0] MASK_LOW6      = 8'h3f;
	localparam logic [7:0] MASK_LOW5      = 8'h1f;
	localparam logic [7:0] MASK_BIT0      = 8'h01;
	localparam logic [7:0] MASK_BIT7      = 8'h80;
	localparam logic [7:0] MASK_CLOCK_MGR = 8'ha7;
	localparam logic [7:0] MASK_AUDIO     = 8'h77;
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_COUNT      = 8'hff;
	localparam logic [7:0] UNLOCK_PATTERN = 8'h58;
	localparam int         STATUS_WDT_BIT = 7;
	// processor status bits
	localparam int PSR_N = 7;
	localparam int PSR_V = 6;
	localparam int PSR_ONE = 5;
	localparam int PSR_B = 4;
	localparam int PSR_D = 3;
	localparam int PSR_I = 2;
	localparam int PSR_Z = 1;
	localparam int PSR_C = 0;
	localparam logic [7:0]  PSR_RESET = 8'h24;
	localparam logic [7:0]  SP_RESET  = 8'hff;
	localparam logic [15:0] PC_RESET  = 16'hfffc;

	typedef enum logic [1:0] {CSAM_RGN_NONE, CSAM_RGN_RAM, CSAM_RGN_SFR,
		CSAM_RGN_ROM} csam_region_t;
	typedef enum logic [1:0] {CSAM_IDX_NONE, CSAM_IDX_X, CSAM_IDX_Y} csam_index_t;
	typedef enum logic [3:0] {CSAM_ALU_PASS, CSAM_ALU_ADC, CSAM_ALU_SBC, CSAM_ALU_CMP,
		CSAM_ALU_AND, CSAM_ALU_ORA, CSAM_ALU_EOR, CSAM_ALU_ASL, CSAM_ALU_LSR,
		CSAM_ALU_ROL, CSAM_ALU_ROR} csam_alu_op_t;
endpackage

// File: tb/csam_core_state_sva.sv
`timescale 1ns/1ps
module csam_core_state_sva
	import csam_pkg::*;
(
	// clock and resets
	input wire logic                  ref_clk, reset_n, low_voltage_reset,
	// requests
	input wire logic                  acc_load, alu_go, psr_load, flag_write, int_entry,
	input wire logic                  int_is_break, pc_load, sp_load, fetch_req, push_req,
	input wire logic                  pull_req, data_req, data_we,
	input wire logic [7:0]            load_data, wdata,
	input wire logic [15:0]           base_addr,
	input wire csam_pkg::csam_index_t index_sel,
	// state and memory side
	input wire logic [7:0]            acc_r, x_r, y_r, psr_r, sp_r, mem_wdata_r,
	input wire logic [15:0]           program_counter_r, addr_bus_r,
	input wire logic [RAM_ADDR_W-1:0] ram_addr_r,
	input wire logic                  ram_sel_r, sfr_sel_r, rom_sel_r, mem_we_r, irq_take_r
);
	logic        dq;
	logic [15:0] ea;
	// data access only when no higher request wins the cycle
	assign dq = data_req && !fetch_req && !push_req && !pull_req;
	assign ea = base_addr + ((index_sel == CSAM_IDX_X) ? {8'h00, x_r} :
		(index_sel == CSAM_IDX_Y) ? {8'h00, y_r} : 16'h0000);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n || low_voltage_reset);
	a_psr_one_bit: assert property (psr_r[PSR_ONE])
		else $error("status bit 5 low");
	a_fetch_addr: assert property (fetch_req |=> addr_bus_r == $past(program_counter_r)
		&& rom_sel_r == $past(program_counter_r[15])) else $error("fetch address wrong");
	a_pc_step: assert property (fetch_req && !pc_load |=>
		program_counter_r == $past(program_counter_r) + 16'h0001) else $error("pc no step");
	a_index_add: assert property (dq |=> addr_bus_r == $past(ea))
		else $error("indexed address wrong");
	a_ram_mirror: assert property (dq && (ea[15:7] == 9'h000 || ea[15:7] == 9'h002) |=>
		ram_sel_r && !sfr_sel_r && ram_addr_r == $past(ea[6:0])) else $error("ram decode");
	a_ram_write: assert property (dq && data_we && ea[15:7] == 9'h000 |=>
		mem_we_r && mem_wdata_r == $past(wdata)) else $error("ram write lost");
	a_sfr_window: assert property (dq && ea[15:6] == 10'h003 |=>
		sfr_sel_r && !ram_sel_r && !rom_sel_r) else $error("sfr decode");
	a_push_step: assert property (push_req && !fetch_req && !sp_load |=>
		sp_r == $past(sp_r) - 8'h01 && addr_bus_r == {STACK_PAGE, $past(sp_r)})
		else $error("push wrong");
	a_load_flags: assert property (acc_load && !alu_go && !psr_load && !flag_write |=>
		acc_r == $past(load_data) && psr_r[PSR_N] == $past(load_data[7])
		&& psr_r[PSR_Z] == ($past(load_data) == 8'h00)) else $error("load flags wrong");
	a_int_entry: assert property (int_entry && !psr_load && !flag_write |=>
		psr_r[PSR_B] == $past(int_is_break) && psr_r[PSR_I]) else $error("entry flags");
	a_irq_masked: assert property (psr_r[PSR_I] |=> !irq_take_r)
		else $error("masked request taken");
	a_lvr_reset: assert property (disable iff (!reset_n) low_voltage_reset |=>
		acc_r == 8'h00 && program_counter_r == PC_RESET && sp_r == SP_RESET)
		else $error("low voltage reset ignored");
endmodule
bind csam_core_state csam_core_state_sva u_sva (.*);

// File: tb/csam_mem_model.sv
`timescale 1ns/1ps
module csam_mem_model
	import csam_pkg::*;
(
	// clock
	input wire logic                  ref_clk,
	// memory side of the core
	input wire logic                  ram_sel_r,
	input wire logic                  rom_sel_r,
	input wire logic                  mem_we_r,
	input wire logic [RAM_ADDR_W-1:0] ram_addr_r,
	input wire logic [7:0]            mem_wdata_r,
	input wire logic [15:0]           addr_bus_r,
	// read data back
	output logic [7:0]                rd_data
);
	logic [7:0] ram [128];
	logic [7:0] junk_r;
	always @(posedge ref_clk) begin
		junk_r <= junk_r + 8'h5b;
		if (mem_we_r && ram_sel_r) begin
			ram[ram_addr_r] <= mem_wdata_r;
		end
	end
	initial junk_r = 8'h3c;
	// fixed rom pattern; unselected bus keeps changing
	assign rd_data = rom_sel_r ? (addr_bus_r[15:8] ^ addr_bus_r[7:0]) :
		ram_sel_r ? ram[ram_addr_r] : junk_r;
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import csam_pkg::*;
	logic                  ref_clk, reset_n, low_voltage_reset, acc_load, x_load, y_load;
	logic                  psr_load, flag_write, flag_value, int_entry, int_is_break, c;
	logic                  pc_load, sp_load, alu_go, fetch_req, push_req, pull_req, data_req;
	logic                  data_we, hardware_interrupt_request, vdd1_level, ram_sel_r;
	logic                  sfr_sel_r, rom_sel_r, mem_we_r, irq_take_r, unlocked_r;
	logic [2:0]            flag_index;
	logic [7:0]            load_data, alu_operand, wdata, irq_event, acc_r, x_r, y_r;
	logic [7:0]            psr_r, sp_r, mem_wdata_r, sfr_rdata_r, rd_data, a, b;
	logic [8:0]            s;
	logic [15:0]           pc_in, base_addr, program_counter_r, addr_bus_r, ad;
	logic [RAM_ADDR_W-1:0] ram_addr_r;
	csam_alu_op_t          alu_op;
	csam_index_t           index_sel;
	int                    num_errors, n_checks, seed, i, k;
	logic [15:0]           dflt [19] = '{16'hc300, 16'hc8ff, 16'hc900, 16'hcaff, 16'hcb00,
		16'hccff, 16'hcdff, 16'hce00, 16'hcf00, 16'hd200, 16'hd500, 16'hdf00, 16'he000,
		16'hed00, 16'hf200, 16'hf700, 16'hc500, 16'hf300, 16'hc180};
	logic [15:0]           edges [11] = '{16'h007f, 16'h0080, 16'h00bf, 16'h00c0, 16'h00ff,
		16'h0100, 16'h017f, 16'h0180, 16'h7fff, 16'h8000, 16'hffff};

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	csam_core_state u_csam_core_state (.*);
	csam_mem_model u_csam_mem_model (.*);

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// strobes drop at the sampling edge by nba, so no signal gets two writes per step
	task automatic step();
		@(posedge ref_clk);
		{acc_load, x_load, y_load, psr_load, flag_write, int_entry, pc_load} <= '0;
		{sp_load, alu_go, fetch_req, push_req, pull_req, data_req, data_we} <= '0;
		low_voltage_reset <= 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic rd(input logic [15:0] base, input int ix, input logic we);
		data_req = 1'b1;
		data_we = we;
		base_addr = base;
		index_sel = csam_index_t'(ix);
		step();
	endtask
	function automatic logic [2:0] region(input logic [15:0] v);
		region = {v < 16'h0080 || (v >= 16'h0100 && v < 16'h0180), v[15:6] == 10'h003, v[15]};
	endfunction
	// subtract is biased by 100 so carry means no borrow
	function automatic logic [8:0] bcd_add(input logic [7:0] x, y, input logic ci, sub);
		int t;
		int u;
		t = x[7:4] * 10 + x[3:0];
		u = y[7:4] * 10 + y[3:0];
		t = sub ? t - u - 1 + ci + 100 : t + u + ci;
		bcd_add = {t > 99, 4'(t % 100 / 10), 4'(t % 10)};
	endfunction
	function automatic logic [8:0] alu_ref(input csam_alu_op_t op, input logic [7:0] x, y,
		input logic ci);
		case (op)
			CSAM_ALU_SBC: alu_ref = 9'(x) + {1'b0, ~y} + 9'(ci);
			CSAM_ALU_CMP: alu_ref = 9'(x) + {1'b0, ~y} + 9'h001;
			CSAM_ALU_AND: alu_ref = {ci, x & y};
			CSAM_ALU_ORA: alu_ref = {ci, x | y};
			CSAM_ALU_EOR: alu_ref = {ci, x ^ y};
			CSAM_ALU_ASL: alu_ref = {x, 1'b0};
			CSAM_ALU_LSR: alu_ref = {x[0], 1'b0, x[7:1]};
			CSAM_ALU_ROL: alu_ref = {x, ci};
			CSAM_ALU_ROR: alu_ref = {x[0], ci, x[7:1]};
			default: alu_ref = 9'(x) + 9'(y) + 9'(ci);
		endcase
	endfunction
	task automatic results();
		if (num_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		seed = 32'hd2b4a92b;
		{num_errors, n_checks, reset_n, flag_index, flag_value, int_is_break} = '0;
		{load_data, alu_operand, wdata, irq_event, pc_in, base_addr} = '0;
		{hardware_interrupt_request, vdd1_level} = 2'b01;
		alu_op = CSAM_ALU_ADC;
		index_sel = CSAM_IDX_NONE;
		step();
		step();
		reset_n = 1'b1;
		step();
		chk("psr", 16'(psr_r), 16'h0024);
		foreach (dflt[j]) begin
			rd({8'h00, dflt[j][15:8]}, 0, 1'b0);
			chk("sfr", 16'(sfr_rdata_r), 16'(dflt[j][7:0]));
		end
		for (i = 0; i < 42; i++) begin
			a = $random(seed);
			b = $random(seed);
			c = (i > 1) & b[0];
			if (i < 2) begin
				a = {i[0], 7'h7f};
				b = 8'h01;
			end
			if (i / 8 == 2) begin
				a = {4'(a[7:4] % 10), 4'(a[3:0] % 10)};
				b = {4'(b[7:4] % 10), 4'(b[3:0] % 10)};
			end
			load_data = {4'h2, i / 8 == 2, 2'b00, c};
			psr_load = 1'b1;
			alu_op = csam_alu_op_t'(i < 20 ? 1 : i < 24 ? 2 : 2 + i % 9);
			step();
			load_data = a;
			acc_load = 1'b1;
			step();
			alu_go = 1'b1;
			alu_operand = b;
			step();
			s = (i / 8 == 2) ? bcd_add(a, b, c, i >= 20) : alu_ref(alu_op, a, b, c);
			chk("acc", 16'(acc_r), 16'(alu_op == CSAM_ALU_CMP ? a : s[7:0]));
			chk("carry", 16'(psr_r[PSR_C]), 16'(s[8]));
			if (i / 8 != 2) begin
				chk("zero", 16'(psr_r[PSR_Z]), 16'(s[7:0] == 8'h00));
				chk("sign", 16'(psr_r[PSR_N]), 16'(s[7]));
				if (i < 16) chk("ovf", 16'(psr_r[PSR_V]), 16'(a[7] == b[7] && s[7] != a[7]));
			end
		end
		for (i = 0; i < 8; i++) begin
			if (!i[0]) load_data = $random(seed);
			psr_load = !i[0];
			flag_write = i[0];
			flag_index = 3'd5;
			step();
			chk("psr", 16'(psr_r), 16'(load_data | 8'h20));
		end
		a = $random(seed);
		b = $random(seed);
		load_data = a;
		x_load = 1'b1;
		step();
		load_data = b;
		y_load = 1'b1;
		step();
		for (i = 0; i < 60; i++) begin
			ad = (i < 11) ? edges[i] : 16'($random(seed));
			k = (i < 11) ? 0 : $unsigned($random(seed)) % 3;
			rd(ad, k, 1'b0);
			ad = ad + ((k == 1) ? {8'h00, a} : (k == 2) ? {8'h00, b} : 16'h0000);
			chk("addr", addr_bus_r, ad);
			chk("region", 16'({ram_sel_r, sfr_sel_r, rom_sel_r}), 16'(region(ad)));
		end
		for (i = 0; i < 6; i++) begin
			ad = {7'h00, i[0], 1'b0, 7'($random(seed))};
			wdata = $random(seed);
			rd(ad, 0, 1'b1);
			step();
			rd(ad ^ 16'h0100, 0, 1'b0);
			chk("mirror", 16'(rd_data), 16'(wdata));
		end
		for (i = 0; i < 3; i++) begin
			wdata = (i == 1) ? UNLOCK_PATTERN : 8'hff;
			rd(16'(i == 1 ? OFS_WRITE_UNLOCK_KEY : OFS_MAIN_CLOCK_MANAGER), 0, 1'b1);
			chk("unlock", 16'(unlocked_r), 16'(i == 1));
			rd(16'(OFS_MAIN_CLOCK_MANAGER), 0, 1'b0);
			chk("clkmgr", 16'(sfr_rdata_r), 16'(i == 2 ? MASK_CLOCK_MGR : RST_ZERO));
		end
		irq_event = 8'h0c;
		step();
		irq_event = 8'h00;
		wdata = 8'h84;
		rd(16'(OFS_INTERRUPT_STATUS), 0, 1'b1);
		rd(16'(OFS_INTERRUPT_STATUS), 0, 1'b0);
		chk("irq status", 16'(sfr_rdata_r), 16'h0008);
		ad = {1'b1, 15'($random(seed))};
		pc_in = ad;
		pc_load = 1'b1;
		step();
		for (i = 0; i < 4; i++) begin
			fetch_req = 1'b1;
			step();
			chk("fetch", addr_bus_r, ad + 16'(i));
			chk("pc", program_counter_r, ad + 16'(i + 1));
		end
		a = {2'b01, 6'($random(seed))};
		load_data = a;
		sp_load = 1'b1;
		step();
		for (i = 0; i < 3; i++) begin
			push_req = (i < 2);
			pull_req = (i == 2);
			step();
			chk("stack", addr_bus_r, {STACK_PAGE, a - 8'(i > 0)});
			chk("sp", 16'(sp_r), 16'(a - 8'(i < 2 ? i + 1 : 1)));
		end
		for (i = 0; i < 4; i++) begin
			int_entry = (i < 2);
			int_is_break = i[0];
			flag_write = (i > 1);
			flag_index = 3'd2;
			flag_value = i[0];
			hardware_interrupt_request = (i > 1);
			step();
			chk("mask", 16'(psr_r[PSR_I]), 16'(i != 2));
			for (k = 0; k < 3; k++) step();
			chk("take", 16'(irq_take_r), 16'(i == 2));
			if (i < 2) chk("break", 16'(psr_r[PSR_B]), 16'(i[0]));
		end
		low_voltage_reset = 1'b1;
		step();
		chk("lvr acc", 16'(acc_r), 16'h0000);
		chk("lvr pc", program_counter_r, PC_RESET);
		chk("lvr sp", 16'(sp_r), 16'(SP_RESET));
		// one more edge so the reset assertion completes
		step();
		results();
	end
endmodule
